// File: design/systk_consts.svh
// Constants for the system tick timer: offsets, fields, reset values
// Summary of operation
// - Flag reads one after zero, read clears
// - Clock select 0 external, 1 processor clock
// - Exception request only when enable bit set
// - Enable loads reload value then counts down
// - At zero set flag, request, reload, continue
// - Reload field bits 23:0, upper bits reserved
// - Flag and request only on 1-to-0 step
// - Current value read returns counter value
// - Any current value write clears counter, flag
// - Calibration bit 31 shows no reference clock
// - Without reference clock, select reads one
// - Calibration bit 30 shows inexact calibration
// - Calibration field holds ten-millisecond reload count
// - Calibration field resets to 0x3a98
// - 24-bit counter wraps to reload after zero
// - Counter holds while processor debug-halted
`ifndef SYSTK_CONSTS_SVH
`define SYSTK_CONSTS_SVH

`define SYSTK_OFF_CTRL 32'he000e010
`define SYSTK_OFF_RELOAD 32'he000e014
`define SYSTK_OFF_CURRENT 32'he000e018
`define SYSTK_OFF_CALIB 32'he000e01c
`define SYSTK_OFF_IRQ_STATUS 32'he000e020
`define SYSTK_OFF_IRQ_MASK 32'he000e024

`define SYSTK_BIT_ENABLE 0
`define SYSTK_BIT_TICK_EXCEPTION_ENABLE 1
`define SYSTK_BIT_CLKSEL 2
`define SYSTK_BIT_FLAG 16
`define SYSTK_BIT_NO_REFERENCE_CLOCK 31
`define SYSTK_BIT_SKEW 30

`define SYSTK_CTRL_RESET 32'h00000000
`define SYSTK_TEN_MILLISECOND_COUNT_RESET 24'h003a98

`endif

// File: design/systk_pkg.sv
// Types shared by the system tick timer
package systk_pkg;
    typedef logic [23:0] systk_count_t;
    typedef enum logic [1:0] {
        SYSTK_IDLE = 2'b00,
        SYSTK_LOAD = 2'b01,
        SYSTK_RUN = 2'b10
    } systk_state_e;
endpackage : systk_pkg

// File: design/systk_timer.sv
// System tick down counter with APB register slave
`include "systk_consts.svh"
module systk_timer
    import systk_pkg::*;
#(
    parameter logic NO_REF_CLOCK = 1'b0,
    parameter logic TEN_MILLISECOND_COUNT_SKEW = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ref_clk,
    input wire logic debug_halt,
    output logic tick_request,
    output logic irq
);
    logic [2:0] ref_sync_ff;
    logic debug_sync1_ff;
    logic debug_sync2_ff;
    logic enable_ff;
    logic tick_exception_enable_ff;
    logic clksel_ff;
    logic flag_ff;
    systk_count_t reload_ff;
    systk_count_t count_ff;
    systk_count_t ten_millisecond_count_ff;
    systk_state_e state_ff;
    logic [1:0] irq_status_ff;
    logic [1:0] irq_mask_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic tick_request_ff;
    logic irq_ff;

    logic setup;
    logic access;
    logic rd_setup;
    logic wr;
    logic rd;
    logic clk_sel_eff;
    logic step;
    logic zero_hit;
    logic hit;
    logic [31:0] nxt_rdata;

    // Read data fetched in setup; effects land at the ready edge
    assign setup = psel && !penable;
    assign access = psel && penable && pready_ff;
    assign rd_setup = setup && !pwrite;
    assign wr = access && pwrite;
    assign rd = access && !pwrite;

    // Reference clock is a pin: two flops, then edge detect on 2nd/3rd
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_sync_ff <= 3'h0;
            debug_sync1_ff <= 1'b0;
            debug_sync2_ff <= 1'b0;
        end else begin
            ref_sync_ff <= {ref_sync_ff[1:0], ref_clk};
            debug_sync1_ff <= debug_halt;
            debug_sync2_ff <= debug_sync1_ff;
        end
    end

    assign clk_sel_eff = NO_REF_CLOCK ? 1'b1 : clksel_ff;
    assign step = !debug_sync2_ff &&
        (clk_sel_eff || (ref_sync_ff[1] && !ref_sync_ff[2]));
    assign zero_hit = (state_ff == SYSTK_RUN) && enable_ff && step &&
        (count_ff == 24'h000001);

    always_comb begin
        hit = 1'b1;
        nxt_rdata = 32'h00000000;
        if (paddr == `SYSTK_OFF_CTRL) begin
            nxt_rdata[`SYSTK_BIT_ENABLE] = enable_ff;
            nxt_rdata[`SYSTK_BIT_TICK_EXCEPTION_ENABLE] = tick_exception_enable_ff;
            nxt_rdata[`SYSTK_BIT_CLKSEL] = clk_sel_eff;
            nxt_rdata[`SYSTK_BIT_FLAG] = flag_ff;
        end else if (paddr == `SYSTK_OFF_RELOAD) begin
            nxt_rdata = {8'h00, reload_ff};
        end else if (paddr == `SYSTK_OFF_CURRENT) begin
            nxt_rdata = {8'h00, count_ff};
        end else if (paddr == `SYSTK_OFF_CALIB) begin
            nxt_rdata = {NO_REF_CLOCK, TEN_MILLISECOND_COUNT_SKEW, 6'h00, ten_millisecond_count_ff};
        end else if (paddr == `SYSTK_OFF_IRQ_STATUS) begin
            nxt_rdata = {30'h00000000, irq_status_ff};
        end else if (paddr == `SYSTK_OFF_IRQ_MASK) begin
            nxt_rdata = {30'h00000000, irq_mask_ff};
        end else begin
            hit = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup && !hit;
            if (rd_setup) begin
                prdata_ff <= nxt_rdata;
            end
        end
    end

    // Control bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_ff <= 1'b0;
            tick_exception_enable_ff <= 1'b0;
            clksel_ff <= 1'b0;
        end else if (wr && paddr == `SYSTK_OFF_CTRL) begin
            enable_ff <= pwdata[`SYSTK_BIT_ENABLE];
            tick_exception_enable_ff <= pwdata[`SYSTK_BIT_TICK_EXCEPTION_ENABLE];
            clksel_ff <= pwdata[`SYSTK_BIT_CLKSEL];
        end
    end

    // Reload value: reset is undefined in the device, zero here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_ff <= 24'h000000;
            ten_millisecond_count_ff <= `SYSTK_TEN_MILLISECOND_COUNT_RESET;
        end else if (wr && paddr == `SYSTK_OFF_RELOAD) begin
            reload_ff <= pwdata[23:0];
        end
    end

    // Count state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= SYSTK_IDLE;
            count_ff <= 24'h000000;
        end else if (wr && paddr == `SYSTK_OFF_CURRENT) begin
            count_ff <= 24'h000000;
            if (state_ff != SYSTK_IDLE) begin
                state_ff <= SYSTK_RUN;
            end
        end else begin
            case (state_ff)
                SYSTK_IDLE: begin
                    if (enable_ff) begin
                        state_ff <= SYSTK_LOAD;
                    end
                end
                SYSTK_LOAD: begin
                    count_ff <= reload_ff;
                    state_ff <= enable_ff ? SYSTK_RUN : SYSTK_IDLE;
                end
                SYSTK_RUN: begin
                    if (!enable_ff) begin
                        state_ff <= SYSTK_IDLE;
                    end else if (step) begin
                        if (count_ff == 24'h000000) begin
                            count_ff <= reload_ff;
                        end else begin
                            count_ff <= count_ff - 24'h000001;
                        end
                    end
                end
                default: begin
                    state_ff <= SYSTK_IDLE;
                end
            endcase
        end
    end

    // Zero flag: hardware set wins over read clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_ff <= 1'b0;
        end else if (zero_hit) begin
            flag_ff <= 1'b1;
        end else if ((rd && paddr == `SYSTK_OFF_CTRL) ||
                     (wr && paddr == `SYSTK_OFF_CURRENT)) begin
            flag_ff <= 1'b0;
        end
    end

    // Status bit 0: zero reached, bit 1: exception request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_ff <= 2'h0;
            irq_mask_ff <= 2'h0;
        end else begin
            if (wr && paddr == `SYSTK_OFF_IRQ_STATUS) begin
                irq_status_ff <= irq_status_ff & ~pwdata[1:0];
            end
            if (zero_hit) begin
                irq_status_ff[0] <= 1'b1;
                if (tick_exception_enable_ff) begin
                    irq_status_ff[1] <= 1'b1;
                end
            end
            if (wr && paddr == `SYSTK_OFF_IRQ_MASK) begin
                irq_mask_ff <= pwdata[1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_request_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            tick_request_ff <= zero_hit && tick_exception_enable_ff;
            irq_ff <= |(irq_status_ff & irq_mask_ff);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign tick_request = tick_request_ff;
    assign irq = irq_ff;
endmodule : systk_timer

// File: testbench/systk_checker.sv
// Port-level assertions for the system tick timer
`include "systk_consts.svh"
module systk_checker #(
    parameter logic NO_REF_CLOCK = 1'b0,
    parameter logic TEN_MILLISECOND_COUNT_SKEW = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ref_clk,
    input wire logic debug_halt,
    input wire logic tick_request,
    input wire logic irq
);
    logic setup;
    logic rd;
    logic mapped;
    assign setup = psel && !penable;
    assign rd = setup && !pwrite;
    // Only aligned words from control up to mask decode
    assign mapped = paddr >= `SYSTK_OFF_CTRL && paddr <= `SYSTK_OFF_IRQ_MASK &&
        paddr[1:0] == 2'b00;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_next: assert property (setup |=> pready)
        else $error("pready missing after setup");
    a_ready_once: assert property (pready |=> !pready)
        else $error("pready held two cycles");
    a_err_unmapped: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (setup && mapped |=> !pslverr)
        else $error("mapped access refused");
    a_calib_value: assert property (rd && paddr == `SYSTK_OFF_CALIB |=>
        prdata == {NO_REF_CLOCK, TEN_MILLISECOND_COUNT_SKEW, 6'h00, `SYSTK_TEN_MILLISECOND_COUNT_RESET})
        else $error("calibration word wrong");
    a_upper_zero: assert property (rd && (paddr == `SYSTK_OFF_RELOAD ||
        paddr == `SYSTK_OFF_CURRENT) |=> prdata[31:24] == 8'h00)
        else $error("reserved bits not zero");
    a_req_single: assert property (tick_request |=> !tick_request)
        else $error("request longer than one cycle");
    a_halt_quiet: assert property (debug_halt [*6] |-> !tick_request)
        else $error("request while halted");
    a_mask_off: assert property (setup && pwrite && paddr == `SYSTK_OFF_IRQ_MASK &&
        pwdata[1:0] == 2'b00 |-> ##3 !irq)
        else $error("irq with all masked");
endmodule : systk_checker

bind systk_timer systk_checker #(.NO_REF_CLOCK(NO_REF_CLOCK), .TEN_MILLISECOND_COUNT_SKEW(TEN_MILLISECOND_COUNT_SKEW)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_clk(ref_clk), .debug_halt(debug_halt), .tick_request(tick_request), .irq(irq));

// File: testbench/systk_core_model.sv
// Core-side model: reference clock, debug halt, request counter
module systk_core_model (
    input wire logic pclk,
    input wire logic halt_req,
    input wire logic tick_request,
    output logic ref_clk,
    output logic debug_halt,
    output int n_req
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div_ff = 2'h0;
    initial ref_clk = 1'b0;
    initial debug_halt = 1'b0;
    initial n_req = 0;
    // Free-running reference at one eighth of pclk
    always @(posedge pclk) begin
        div_ff <= div_ff + 2'h1;
        if (div_ff == 2'h3) ref_clk <= !ref_clk;
        debug_halt <= halt_req;
        if (tick_request === 1'b1) n_req <= n_req + 1;
    end
endmodule : systk_core_model

// File: testbench/systk_timer_tb.sv
// Self-checking bench for the system tick timer
`include "systk_consts.svh"
module systk_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, halt_req, pready, pslverr, e;
    logic ref_clk, debug_halt, tick_request, irq;
    logic [31:0] paddr, pwdata, prdata, r;
    int failures, n_checks, n_req, c;
    always #10 pclk = ~pclk;
    systk_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ref_clk(ref_clk), .debug_halt(debug_halt),
        .tick_request(tick_request), .irq(irq));
    systk_core_model u_core (.pclk(pclk), .halt_req(halt_req), .tick_request(tick_request),
        .ref_clk(ref_clk), .debug_halt(debug_halt), .n_req(n_req));
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic ck(input string n, input logic [31:0] x, input logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            failures++;
            $display("BAD %s exp %h got %h", n, x, g);
        end
    endtask : ck
    task automatic t_regs;
        apb(0, `SYSTK_OFF_CTRL, 0);
        ck("ctrl", 32'h00000000, r);
        apb(0, `SYSTK_OFF_CALIB, 0);
        ck("calib", 32'h00003a98, r);
        apb(1, `SYSTK_OFF_RELOAD, 32'hffffffff);
        apb(0, `SYSTK_OFF_RELOAD, 0);
        ck("reload", 32'h00ffffff, r);
        apb(0, 32'he000e028, 0);
        ck("pslverr", 32'h1, e);
        apb(1, `SYSTK_OFF_CURRENT, 32'h5a5a5a5a);
        apb(0, `SYSTK_OFF_CURRENT, 0);
        ck("current", 32'h0, r);
    endtask : t_regs
    // Second gap measured, the first includes the load
    task automatic t_period(input logic [31:0] ctl, input int x);
        apb(1, `SYSTK_OFF_RELOAD, 32'h3);
        apb(1, `SYSTK_OFF_CURRENT, 0);
        apb(1, `SYSTK_OFF_CTRL, ctl);
        do @(posedge pclk); while (tick_request !== 1'b1);
        c = 0;
        do begin
            @(posedge pclk);
            c++;
        end while (tick_request !== 1'b1);
        ck("gap", x, c);
        apb(1, `SYSTK_OFF_CTRL, 0);
    endtask : t_period
    task automatic t_quiet(input logic [31:0] rl, input logic [31:0] fl);
        apb(1, `SYSTK_OFF_RELOAD, rl);
        apb(1, `SYSTK_OFF_CTRL, 32'h5);
        c = n_req;
        repeat (20) @(posedge pclk);
        apb(1, `SYSTK_OFF_CTRL, 32'h4);
        ck("requests", c, n_req);
        apb(0, `SYSTK_OFF_CTRL, 0);
        ck("flag", fl, r);
        apb(0, `SYSTK_OFF_CTRL, 0);
        ck("flag_clr", 32'h4, r);
    endtask : t_quiet
    task automatic t_irq;
        apb(1, `SYSTK_OFF_IRQ_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        ck("irq", 32'h1, irq);
        apb(1, `SYSTK_OFF_IRQ_STATUS, 32'h3);
        repeat (2) @(posedge pclk);
        ck("irq_clr", 32'h0, irq);
        apb(1, `SYSTK_OFF_IRQ_MASK, 32'h0);
    endtask : t_irq
    task automatic t_halt;
        apb(1, `SYSTK_OFF_RELOAD, 32'hff);
        apb(1, `SYSTK_OFF_CTRL, 32'h7);
        halt_req <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(0, `SYSTK_OFF_CURRENT, 0);
        c = r;
        repeat (9) @(posedge pclk);
        apb(0, `SYSTK_OFF_CURRENT, 0);
        ck("halted", c, r);
        halt_req <= 1'b0;
        apb(1, `SYSTK_OFF_CTRL, 0);
    endtask : t_halt
    task automatic end_sim;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim
    initial begin
        {pclk, presetn, psel, penable, pwrite, halt_req} = 6'h00;
        {paddr, pwdata} = 64'h0;
        failures = 0;
        n_checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_period(32'h7, 4);
        t_period(32'h3, 32);
        t_quiet(32'h3, 32'h00010004);
        t_irq;
        t_quiet(32'h0, 32'h00000004);
        t_halt;
        end_sim;
    end
    // Whole run is well under two thousand cycles
    initial begin
        #100000;
        failures++;
        end_sim;
    end
endmodule : systk_timer_tb
